// [common/bpcirq_pkg.sv]
// shared constants for the two-port gpio block with change detection
package bpcirq_pkg;
   localparam int PORT_W = 8;
   localparam logic [31:0] ADDR_INTCTL = 32'h0000000B * 32'h4;
   localparam logic [31:0] ADDR_DIR3 = 32'h00000087 * 32'h4;
   localparam logic [31:0] ADDR_DATA2 = 32'h00000006 * 32'h4;
   localparam logic [31:0] ADDR_DIR2 = 32'h00000086 * 32'h4;
   localparam logic [31:0] ADDR_OPTION = 32'h00000081 * 32'h4;
   localparam logic [31:0] ADDR_DATA3 = 32'h00000007 * 32'h4;
   localparam logic [31:0] ADDR_PSEL3 = 32'h00000088 * 32'h4;
   localparam logic [31:0] ADDR_SLEEP = 32'h00000089 * 32'h4;
   localparam int OPT_PULLUP_N_BIT = 7;
   localparam int ICTL_FLAG_BIT = 0;
   localparam int ICTL_IE_BIT = 3;
   localparam int SLP_BIT = 0;
   localparam int CHG_LO = 4;
   localparam int CHG_HI = 7;
   localparam logic [7:0] DIR_RESET = 8'hFF;
   localparam logic [7:0] OPTION_RESET = 8'hFF;
   localparam logic [7:0] ZERO8 = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/bpcirq_sync8.sv]
// two-flop synchroniser for an eight-bit pin group
`timescale 1ns/1ps
module bpcirq_sync8 (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // data
   input wire logic [7:0] d_i,
   output logic [7:0] q_o
);
   logic [7:0] meta_reg;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_reg <= 8'h00;
         q_o <= 8'h00;
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule // bpcirq_sync8

// [rtl/bpcirq_top.sv]
// two gpio ports, pull-ups, change detection and peripheral override
// Behaviour
// - second port direction one makes pin input, driver high impedance
// - second port direction zero drives the output latch onto the pin
// - second port has eight pins each with its own direction bit
// - option bit 7 low enables all second port pull-ups
// - pull-up is off on any pin configured as output
// - reset leaves pull-ups disabled
// - only input pins 7 to 4 take part in change detection
// - inputs compare against last-read latch; ORed mismatch sets flag bit 0
// - a port change event wakes the device from sleep
// - any read of second port data, or a write with byte lane 0 on, refreshes the latch
// - flag keeps setting while mismatch lasts, clear only holds afterwards
// - pin 0 shared with external interrupt, pin 1 with slave select
// - pin 2 shared with analog channel 8, pin 3 channel 9 and low-volt
// - third port is eight pins with the same direction encoding
// - enabled peripheral may force a third port pin to output or input
// - per-pin select picks port latch or peripheral data for the pin
// - peripheral output enable acts only while its select is active
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
module bpcirq_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // axi4-lite write address
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // second port pins
   input wire logic [7:0] second_port_pin_i,
   output logic [7:0] second_port_pin_o,
   output logic [7:0] second_port_pin_oe_o,
   output logic [7:0] second_port_pullup_o,
   // second port shared functions
   output logic ext_irq_pin_o,
   output logic slave_select_pin_o,
   output logic analog_ch8_pin_o,
   output logic analog_ch9_lowvolt_pin_o,
   // third port pins
   input wire logic [7:0] third_port_pin_i,
   output logic [7:0] third_port_pin_o,
   output logic [7:0] third_port_pin_oe_o,
   // third port peripheral side
   input wire logic [7:0] periph_en_i,
   input wire logic [7:0] periph_force_out_i,
   input wire logic [7:0] periph_data_i,
   input wire logic [7:0] periph_oe_i,
   output logic [7:0] third_port_in_o,
   // power state
   output logic sleep_o,
   output logic wake_o
);
   logic [7:0] data2_reg, dir2_reg, option_reg, data3_reg, dir3_reg, psel3_reg;
   logic [7:0] last_read_reg;
   logic flag_reg, ie_reg, sleep_reg;
   logic [7:0] pin2_s, pin3_s;
   logic [31:0] awaddr_reg, wdata_reg, rdata_next;
   logic [3:0] wstrb_reg;
   logic aw_full_reg, w_full_reg;
   logic wr_go, rd_go, wr_hit, rd_hit;
   logic data2_touch, flag_clr;
   logic wr_data2, wr_dir2, wr_option, wr_data3, wr_dir3, wr_psel3, wr_intctl, wr_sleep;
   logic [3:0] chg_mis;
   logic mismatch;
   logic [7:0] dir3_eff;

   bpcirq_sync8 u_sync2 (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .d_i(second_port_pin_i),
      .q_o(pin2_s)
   );
   bpcirq_sync8 u_sync3 (
      .clk_i(clk_i),
      .arst_n_i(arst_n_i),
      .d_i(third_port_pin_i),
      .q_o(pin3_s)
   );

   // write channel: address and data accepted in either order, held until response
   assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
   assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
   assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         aw_full_reg <= 1'b0;
         w_full_reg <= 1'b0;
         awaddr_reg <= 32'h00000000;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_full_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end else if (wr_go) begin
            w_full_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      wr_hit = 1'b1;
      unique case ({awaddr_reg[31:2], 2'b00})
         bpcirq_pkg::ADDR_INTCTL, bpcirq_pkg::ADDR_DIR3, bpcirq_pkg::ADDR_DATA2,
         bpcirq_pkg::ADDR_DIR2, bpcirq_pkg::ADDR_OPTION, bpcirq_pkg::ADDR_DATA3,
         bpcirq_pkg::ADDR_PSEL3, bpcirq_pkg::ADDR_SLEEP: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= bpcirq_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? bpcirq_pkg::RESP_OKAY : bpcirq_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // only byte lane 0 carries register data; a write with that lane off changes nothing
   always_comb begin
      wr_data2 = 1'b0;
      wr_dir2 = 1'b0;
      wr_option = 1'b0;
      wr_data3 = 1'b0;
      wr_dir3 = 1'b0;
      wr_psel3 = 1'b0;
      wr_intctl = 1'b0;
      wr_sleep = 1'b0;
      if (wr_go && wstrb_reg[0]) begin
         unique case ({awaddr_reg[31:2], 2'b00})
            bpcirq_pkg::ADDR_DATA2: wr_data2 = 1'b1;
            bpcirq_pkg::ADDR_DIR2: wr_dir2 = 1'b1;
            bpcirq_pkg::ADDR_OPTION: wr_option = 1'b1;
            bpcirq_pkg::ADDR_DATA3: wr_data3 = 1'b1;
            bpcirq_pkg::ADDR_DIR3: wr_dir3 = 1'b1;
            bpcirq_pkg::ADDR_PSEL3: wr_psel3 = 1'b1;
            bpcirq_pkg::ADDR_INTCTL: wr_intctl = 1'b1;
            bpcirq_pkg::ADDR_SLEEP: wr_sleep = 1'b1;
            default: wr_sleep = 1'b0;
         endcase
      end
   end

   // register writes, one block per register; only the low byte is stored
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         data2_reg <= bpcirq_pkg::ZERO8;
      end else if (wr_data2) begin
         data2_reg <= wdata_reg[bpcirq_pkg::PORT_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dir2_reg <= bpcirq_pkg::DIR_RESET;
      end else if (wr_dir2) begin
         dir2_reg <= wdata_reg[bpcirq_pkg::PORT_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         option_reg <= bpcirq_pkg::OPTION_RESET;
      end else if (wr_option) begin
         option_reg <= wdata_reg[bpcirq_pkg::PORT_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         data3_reg <= bpcirq_pkg::ZERO8;
      end else if (wr_data3) begin
         data3_reg <= wdata_reg[bpcirq_pkg::PORT_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         dir3_reg <= bpcirq_pkg::DIR_RESET;
      end else if (wr_dir3) begin
         dir3_reg <= wdata_reg[bpcirq_pkg::PORT_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         psel3_reg <= bpcirq_pkg::ZERO8;
      end else if (wr_psel3) begin
         psel3_reg <= wdata_reg[bpcirq_pkg::PORT_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ie_reg <= 1'b0;
      end else if (wr_intctl) begin
         ie_reg <= wdata_reg[bpcirq_pkg::ICTL_IE_BIT];
      end
   end

   // read channel: one cycle from address to data
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_go = s_axi_arvalid && s_axi_arready;

   always_comb begin
      rdata_next = 32'h00000000;
      rd_hit = 1'b1;
      unique case ({s_axi_araddr[31:2], 2'b00})
         bpcirq_pkg::ADDR_DATA2: rdata_next[7:0] = pin2_s;
         bpcirq_pkg::ADDR_DIR2: rdata_next[7:0] = dir2_reg;
         bpcirq_pkg::ADDR_OPTION: rdata_next[7:0] = option_reg;
         bpcirq_pkg::ADDR_DATA3: rdata_next[7:0] = pin3_s;
         bpcirq_pkg::ADDR_DIR3: rdata_next[7:0] = dir3_reg;
         bpcirq_pkg::ADDR_PSEL3: rdata_next[7:0] = psel3_reg;
         bpcirq_pkg::ADDR_SLEEP: rdata_next[bpcirq_pkg::SLP_BIT] = sleep_reg;
         bpcirq_pkg::ADDR_INTCTL: begin
            rdata_next[bpcirq_pkg::ICTL_FLAG_BIT] = flag_reg;
            rdata_next[bpcirq_pkg::ICTL_IE_BIT] = ie_reg;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= bpcirq_pkg::RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdata_next;
         s_axi_rresp <= rd_hit ? bpcirq_pkg::RESP_OKAY : bpcirq_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // change detection; polling the data register re-arms the latch and hides edges
   always_comb begin
      data2_touch = wr_data2;
      if (rd_go && ({s_axi_araddr[31:2], 2'b00} == bpcirq_pkg::ADDR_DATA2)) begin
         data2_touch = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         last_read_reg <= bpcirq_pkg::ZERO8;
      end else if (data2_touch) begin
         last_read_reg <= pin2_s;
      end
   end

   for (genvar i = bpcirq_pkg::CHG_LO; i <= bpcirq_pkg::CHG_HI; i++) begin : g_chg
      assign chg_mis[i - bpcirq_pkg::CHG_LO] =
         dir2_reg[i] && (pin2_s[i] != last_read_reg[i]);
   end
   assign mismatch = |chg_mis;

   always_comb begin
      flag_clr = 1'b0;
      if (wr_intctl && !wdata_reg[bpcirq_pkg::ICTL_FLAG_BIT]) begin
         flag_clr = 1'b1;
      end
   end

   // set wins over clear so a live mismatch re-asserts the flag
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         flag_reg <= 1'b0;
      end else if (mismatch) begin
         flag_reg <= 1'b1;
      end else if (flag_clr) begin
         flag_reg <= 1'b0;
      end
   end

   // sleep entered by software, left on an enabled change event
   assign wake_o = flag_reg && ie_reg;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sleep_reg <= 1'b0;
      end else if (wake_o) begin
         sleep_reg <= 1'b0;
      end else if (wr_sleep) begin
         sleep_reg <= wdata_reg[bpcirq_pkg::SLP_BIT];
      end
   end
   assign sleep_o = sleep_reg;

   // second port pin drive
   assign second_port_pin_o = data2_reg;
   assign second_port_pin_oe_o = ~dir2_reg;
   assign second_port_pullup_o =
      option_reg[bpcirq_pkg::OPT_PULLUP_N_BIT] ? 8'h00 : dir2_reg;
   assign ext_irq_pin_o = pin2_s[0];
   assign slave_select_pin_o = pin2_s[1];
   assign analog_ch8_pin_o = pin2_s[2];
   assign analog_ch9_lowvolt_pin_o = pin2_s[3];

   // third port: peripheral may override direction; data mux by select
   // read-modify-write of direction stores the override-free value, so it is safe here
   always_comb begin
      dir3_eff = dir3_reg;
      for (int i = 0; i < bpcirq_pkg::PORT_W; i++) begin
         if (periph_en_i[i]) begin
            dir3_eff[i] = !periph_force_out_i[i];
         end
      end
   end
   assign third_port_pin_o = (psel3_reg & periph_data_i) | (~psel3_reg & data3_reg);
   assign third_port_pin_oe_o = (~dir3_eff & ~psel3_reg)
      | (psel3_reg & periph_oe_i & ~dir3_eff);
   assign third_port_in_o = pin3_s;
endmodule // bpcirq_top

// [sim/bpcirq_pins_model.sv]
// pin-side model: outside drivers of both ports, pull-ups and floating lines of the second port
`timescale 1ns/1ps
module bpcirq_pins_model (
   // clock
   input wire logic clk_i,
   // second port
   input wire logic [7:0] p2_o_i,
   input wire logic [7:0] p2_oe_i,
   input wire logic [7:0] p2_pu_i,
   input wire logic [7:0] p2_ext_en_i,
   input wire logic [7:0] p2_ext_i,
   output logic [7:0] p2_pin_o,
   // third port
   input wire logic [7:0] p3_o_i,
   input wire logic [7:0] p3_oe_i,
   input wire logic [7:0] p3_ext_i,
   output logic [7:0] p3_pin_o
);
   // an undriven, unpulled line wanders every cycle so a stale level never passes
   logic [7:0] float_reg = 8'h55;
   always @(posedge clk_i) float_reg <= ~float_reg;
   assign p2_pin_o = (p2_oe_i & p2_o_i) | (~p2_oe_i & p2_ext_en_i & p2_ext_i)
      | (~p2_oe_i & ~p2_ext_en_i & (p2_pu_i | float_reg));
   assign p3_pin_o = (p3_oe_i & p3_o_i) | (~p3_oe_i & p3_ext_i);
endmodule // bpcirq_pins_model

// [sim/bpcirq_top_monitor.sv]
// port assertions for the two-port gpio block
`timescale 1ns/1ps
module bpcirq_top_monitor (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // bus handshakes
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   // second port
   input wire logic [7:0] second_port_pin_i,
   input wire logic [7:0] second_port_pin_o,
   input wire logic [7:0] second_port_pin_oe_o,
   input wire logic [7:0] second_port_pullup_o,
   input wire logic ext_irq_pin_o,
   input wire logic slave_select_pin_o,
   input wire logic analog_ch8_pin_o,
   input wire logic analog_ch9_lowvolt_pin_o,
   // power
   input wire logic sleep_o,
   input wire logic wake_o
);
   // edges since reset; the synchroniser holds reset values for two of them
   logic [1:0] age_reg;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) age_reg <= 2'h0;
      else if (age_reg != 2'h3) age_reg <= age_reg + 2'h1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   pullup_off_a: assert property (~|(second_port_pullup_o & second_port_pin_oe_o))
      else $error("pull-up on a driven pin");
   reset_state_a: assert property (age_reg == 2'h0 |-> !(|second_port_pullup_o)
      && !(|second_port_pin_oe_o)) else $error("pins not idle after reset");
   shared_pins_a: assert property (age_reg == 2'h3 |-> {analog_ch9_lowvolt_pin_o,
      analog_ch8_pin_o, slave_select_pin_o, ext_irq_pin_o} == $past(second_port_pin_i[3:0], 2))
      else $error("shared pin level wrong");
   oe_hold_a: assert property ($changed(second_port_pin_oe_o) |-> $rose(s_axi_bvalid))
      else $error("drive enable moved without a write");
   latch_hold_a: assert property ($changed(second_port_pin_o) |-> $rose(s_axi_bvalid))
      else $error("latch moved without a write");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
   read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer repeated");
   wake_sleep_a: assert property (wake_o && sleep_o |=> !sleep_o)
      else $error("no wake from sleep");
endmodule // bpcirq_top_monitor

// [sim/test_bidir_port_with_change_irq.sv]
// self-checking bench for the two-port gpio block
`timescale 1ns/1ps
module test_bidir_port_with_change_irq;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rd_d;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, sleep, wake, irq, ss, an8, an9;
   logic [1:0] bresp, rresp, rd_r, wr_r;
   logic [7:0] p2i, p2o, p2oe, p2pu, p3i, p3o, p3oe, p3in, e_oe, e_o;
   logic [7:0] ext2_en = 8'hFF, ext2 = 8'h00, ext3 = 8'h00;
   logic [7:0] pen = 8'h00, pfo = 8'h00, pdat = 8'h00, poe = 8'h00;
   int errors = 0, checks = 0, cyc = 0;
   int dir2, dat2, dir3, dat3, psel;
   always #20 clk_i = ~clk_i;
   bpcirq_top u_bpcirq_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .second_port_pin_i(p2i), .second_port_pin_o(p2o),
      .second_port_pin_oe_o(p2oe), .second_port_pullup_o(p2pu), .ext_irq_pin_o(irq),
      .slave_select_pin_o(ss), .analog_ch8_pin_o(an8), .analog_ch9_lowvolt_pin_o(an9),
      .third_port_pin_i(p3i), .third_port_pin_o(p3o), .third_port_pin_oe_o(p3oe),
      .periph_en_i(pen), .periph_force_out_i(pfo), .periph_data_i(pdat), .periph_oe_i(poe),
      .third_port_in_o(p3in), .sleep_o(sleep), .wake_o(wake));
   bpcirq_pins_model u_bpcirq_pins_model (.clk_i(clk_i), .p2_o_i(p2o), .p2_oe_i(p2oe),
      .p2_pu_i(p2pu), .p2_ext_en_i(ext2_en), .p2_ext_i(ext2), .p2_pin_o(p2i), .p3_o_i(p3o),
      .p3_oe_i(p3oe), .p3_ext_i(ext3), .p3_pin_o(p3i));
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t pins %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bus(input logic [31:0] exp, input logic [1:0] resp);
      checks++;
      if (rd_d !== exp || rd_r !== resp) begin
         errors++;
         $display("BAD %0t read %h/%h expected %h/%h", $time, rd_d, rd_r, exp, resp);
      end
   endtask
   task automatic chk_wr(input logic [1:0] resp);
      checks++;
      if (wr_r !== resp) begin
         errors++;
         $display("BAD %0t write response %h expected %h", $time, wr_r, resp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      logic ta, tw, got;
      got = 1'b0;
      @(posedge clk_i);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!got) begin
         @(negedge clk_i);
         ta = awvalid && awready;
         tw = wvalid && wready;
         got = bvalid;
         wr_r = bresp;
         @(posedge clk_i);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [31:0] a);
      logic ta, got;
      got = 1'b0;
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got) begin
         @(negedge clk_i);
         ta = arvalid && arready;
         got = rvalid;
         rd_d = rdata;
         rd_r = rresp;
         @(posedge clk_i);
         if (ta) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask
   // three edges to the flag, one more for the sleep exit
   task automatic pins(input logic [7:0] v);
      @(posedge clk_i);
      ext2 <= v;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         errors++;
         $display("BAD %0t run too long", $time);
         end_of_test;
      end
   end
   initial begin
      void'($urandom(32'h545F2F1D));
      repeat (12) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(negedge clk_i);
      chk_pin(p2oe, 8'h00);
      chk_pin(p2pu, 8'h00);
      rd(bpcirq_pkg::ADDR_DIR3);
      chk_bus(32'hFF, bpcirq_pkg::RESP_OKAY);
      $display("reset test done, mismatches %0d", errors);
      for (int i = 0; i < 4; i++) begin
         dir2 = $urandom_range(255);
         dat2 = $urandom_range(255);
         @(posedge clk_i);
         ext2 <= 8'($urandom);
         ext2_en <= 8'($urandom);
         wr(bpcirq_pkg::ADDR_DIR2, dir2[7:0]);
         wr(bpcirq_pkg::ADDR_DATA2, dat2[7:0]);
         wr(bpcirq_pkg::ADDR_OPTION, 8'h7F);
         @(negedge clk_i);
         chk_pin(p2oe, ~dir2[7:0]);
         chk_pin(p2o, dat2[7:0]);
         chk_pin(p2pu, dir2[7:0]);
         rd(bpcirq_pkg::ADDR_DATA2);
         chk_bus({24'h0, (dat2[7:0] & ~dir2[7:0]) | (dir2[7:0] & (ext2 | ~ext2_en))},
            bpcirq_pkg::RESP_OKAY);
      end
      @(posedge clk_i);
      ext2_en <= 8'hFF;
      wr(bpcirq_pkg::ADDR_OPTION, 8'hFF);
      @(negedge clk_i);
      chk_pin(p2pu, 8'h00);
      $display("second port test done, mismatches %0d", errors);
      wr(bpcirq_pkg::ADDR_DIR2, 8'hFF);
      pins(8'h00);
      // one read arms the compare; no polling while detection is used
      rd(bpcirq_pkg::ADDR_DATA2);
      wr(bpcirq_pkg::ADDR_INTCTL, 8'h08);
      pins(8'h0F);
      chk_pin({7'h0, wake}, 8'h00);
      pins(8'h2F);
      chk_pin({7'h0, wake}, 8'h01);
      wr(bpcirq_pkg::ADDR_INTCTL, 8'h08);
      @(negedge clk_i);
      chk_pin({7'h0, wake}, 8'h01);
      rd(bpcirq_pkg::ADDR_DATA2);
      wr(bpcirq_pkg::ADDR_INTCTL, 8'h08);
      @(negedge clk_i);
      chk_pin({7'h0, wake}, 8'h00);
      wr(bpcirq_pkg::ADDR_SLEEP, 8'h01);
      chk_wr(bpcirq_pkg::RESP_OKAY);
      @(negedge clk_i);
      chk_pin({7'h0, sleep}, 8'h01);
      pins(8'h6F);
      chk_pin({6'h0, wake, sleep}, 8'h02);
      $display("change test done, mismatches %0d", errors);
      for (int i = 0; i < 4; i++) begin
         psel = $urandom_range(255);
         dir3 = $urandom_range(255);
         dat3 = $urandom_range(255);
         @(posedge clk_i);
         pen <= 8'($urandom) & ~psel[7:0];
         pfo <= 8'($urandom);
         pdat <= 8'($urandom);
         poe <= 8'($urandom);
         ext3 <= 8'($urandom);
         // whole-byte writes only, never read-modify-write under override
         wr(bpcirq_pkg::ADDR_DIR3, dir3[7:0]);
         wr(bpcirq_pkg::ADDR_DATA3, dat3[7:0]);
         wr(bpcirq_pkg::ADDR_PSEL3, psel[7:0]);
         // two more edges so the pin synchroniser shows the new levels
         repeat (2) @(negedge clk_i);
         e_oe = ((pen & pfo) | (~pen & ~dir3[7:0])) & (~psel[7:0] | poe);
         e_o = (psel[7:0] & pdat) | (~psel[7:0] & dat3[7:0]);
         chk_pin(p3oe, e_oe);
         chk_pin(p3o, e_o);
         chk_pin(p3in, (e_oe & e_o) | (~e_oe & ext3));
         rd(bpcirq_pkg::ADDR_DIR3);
         chk_bus({24'h0, dir3[7:0]}, bpcirq_pkg::RESP_OKAY);
      end
      rd(32'h00000100);
      chk_bus(32'h0, bpcirq_pkg::RESP_SLVERR);
      wr(32'h00000100, 8'hFF);
      chk_wr(bpcirq_pkg::RESP_SLVERR);
      $display("third port test done, mismatches %0d", errors);
      end_of_test;
   end
endmodule // test_bidir_port_with_change_irq
bind bpcirq_top bpcirq_top_monitor u_bpcirq_top_monitor (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
   .second_port_pin_i(second_port_pin_i), .second_port_pin_o(second_port_pin_o),
   .second_port_pin_oe_o(second_port_pin_oe_o), .second_port_pullup_o(second_port_pullup_o),
   .ext_irq_pin_o(ext_irq_pin_o), .slave_select_pin_o(slave_select_pin_o),
   .analog_ch8_pin_o(analog_ch8_pin_o), .analog_ch9_lowvolt_pin_o(analog_ch9_lowvolt_pin_o),
   .sleep_o(sleep_o), .wake_o(wake_o));
